/* File: hw/flc_core.sv */
// Floppy control core: reset sources, interface modes, DMA FIFO, phases
// Assumes a classic Wishbone master, a DMA controller on dmaReq/dmaAck
// and a disk data path that streams bytes and marks sector ends.
//
// Overview of operation
// - Drive-state byte shows write-protect, track zero, head, drive select live
// - Pin, power-on, output-register and rate-register resets; all end power-down
// - Pin reset aborts everything and leaves the core idle
// - Leaving reset clears configuration, awaits a command, starts polling
// - Pin reset keeps specify values, sets output reset bit; host clears it
// - Software resets clear core and FIFO; rate bit self-clears, output bit wins
// - Interface mode comes from configuration bits 3:2
// - First mode: output DMA bit gates interrupt and DMA; density high
// - Second mode: DMA bit ignored, always enabled; density active low
// - Third mode: DMA bit gates interrupt and DMA; density active low
// - DMA requests need specify enable; burst mode from configuration bit 1
// - After reset enter command phase; host writes bytes in order
// - Request-for-master drops per byte, returns per parameter, phase advances
// - FIFO acts one byte deep after reset and in command phase
// - Threshold is field plus one, 1 to 16 bytes
// - Disk read: request at 16 minus threshold or sector end, drop when empty
// - Disk write: request on entering execution until FIFO full
// - Transfer ends on terminal count, overrun, underrun or end-of-track sector
// - Host stalling finishes the sector and reports abnormal termination
// - Result starts with interrupt; after last byte flags 1, 0, not busy
`timescale 1ns/1ps
`include "flc_defines.svh"

module flc_core
	import flc_pkg::*;
(
	input  wire logic        ref_clk,
	input  wire logic        rst,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	input  wire logic        wb_we_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_cyc_i,
	output logic             wb_ack_o,
	input  wire logic        systemResetN,
	input  wire logic        writeProtIn,
	input  wire logic        trackZeroIn,
	output logic      [1:0]  driveSelectLines,
	output logic             headSideLine,
	output logic             densitySelect,
	output logic             pollingActive,
	output logic             interruptOut,
	output logic             dmaReq,
	input  wire logic        dmaAck,
	input  wire logic [7:0]  dmaWrData,
	output logic      [7:0]  dmaRdData,
	input  wire logic        terminalCountPulse,
	input  wire logic        diskRdValid,
	input  wire logic [7:0]  diskRdData,
	input  wire logic        diskSectorEnd,
	input  wire logic        diskWrTake,
	output logic      [7:0]  diskWrData
);

	// ****************************************
	// Helpers
	// ****************************************

	// Usable FIFO depth; one byte while the FIFO is off
	function automatic logic [4:0] fifoCap(input logic on);
		fifoCap = on ? `FLC_FIFO_DEPTH : 5'h01;
	endfunction : fifoCap

	// Service threshold in bytes
	function automatic logic [4:0] thrBytes(input logic on,
		input logic [3:0] fld);
		thrBytes = on ? {1'b0, fld} + 5'h01 : 5'h01;
	endfunction : thrBytes

	// ****************************************
	// State
	// ****************************************
	flc_state_t state_r;
	flc_state_t state_nxt;
	logic       acc;
	logic       wr;
	logic       rd;
	logic       gate;
	logic       fifoOn;
	logic       push;
	logic       pop;
	logic [7:0] pushData;
	logic [4:0] cap;
	logic [4:0] thrB;
	logic [4:0] lvl;
	logic [4:0] nc;
	logic [7:0] drvByte;
	logic [7:0] resByte;

	// Interrupt and DMA gate per interface mode
	assign gate = (state_r.mode == MODE_SECOND) | state_r.dorDma;

	// Drive-state byte assembled from the live pins
	assign drvByte = {1'b0, writeProtIn, 1'b1, trackZeroIn, 1'b1,
		state_r.head, state_r.ds};

	// Result byte selected by the read index
	always_comb begin
		unique case (state_r.resIdx)
			2'h0:    resByte = state_r.st0;
			2'h1:    resByte = state_r.ovr ? `FLC_ST_OVRUN : 8'h00;
			default: resByte = state_r.secCnt;
		endcase
	end

	// ****************************************
	// Next-state logic
	// ****************************************
	always_comb begin
		state_nxt = state_r;
		push = 1'b0;
		pop = 1'b0;
		pushData = diskRdData;
		nc = state_r.cnt;
		fifoOn = ~state_r.fifoOff & (state_r.ph == PH_EXEC);
		cap = fifoCap(fifoOn);
		thrB = thrBytes(fifoOn, state_r.thr);
		lvl = (cap > thrB) ? cap - thrB : 5'h01;
		if (!fifoOn) begin
			lvl = 5'h01;
		end

		// Classic slave answers one cycle after the strobe
		state_nxt.ack = wb_cyc_i & wb_stb_i & ~state_r.ack;
		acc = state_nxt.ack;
		wr = acc & wb_we_i;
		rd = acc & ~wb_we_i;
		state_nxt.dsrRst = 1'b0;
		state_nxt.gap = 1'b0;

		// Read mux; unmapped offsets read zero
		state_nxt.dat = 32'h0000_0000;
		if (rd) begin
			unique case (wb_adr_i)
				`FLC_OFS_DOR: state_nxt.dat[7:0] = {3'h0, state_r.head,
					state_r.dorDma, state_r.dorRst, state_r.ds};
				`FLC_OFS_DSR: state_nxt.dat[7:0] = {1'b0,
					state_r.pwrDown, 4'h0, state_r.rate};
				`FLC_OFS_MSR: state_nxt.dat[7:0] = {state_r.request_for_master,
					state_r.transfer_direction_flag, state_r.ph == PH_EXEC, state_r.cb, 4'h0};
				`FLC_OFS_DATA: state_nxt.dat[7:0] =
					(state_r.ph == PH_RES) ? resByte : 8'h00;
				`FLC_OFS_DRV: state_nxt.dat[7:0] = drvByte;
				`FLC_OFS_CRF0: state_nxt.dat[7:0] = {4'h0,
					state_r.mode, state_r.burst, 1'b0};
				`FLC_OFS_SPEC: state_nxt.dat[15:0] = {state_r.specTime,
					7'h00, state_r.specDma};
				`FLC_OFS_CONF: state_nxt.dat[8:0] = {state_r.polling,
					state_r.thr, state_r.pollOff, 2'h0, state_r.fifoOff};
				default: state_nxt.dat = 32'h0000_0000;
			endcase
		end

		// Register writes, low lane then second lane
		if (wr && wb_sel_i[0]) begin
			unique case (wb_adr_i)
				`FLC_OFS_DOR: begin
					state_nxt.ds = wb_dat_i[1:0];
					state_nxt.dorRst = wb_dat_i[`FLC_DOR_RST];
					state_nxt.dorDma = wb_dat_i[`FLC_DOR_DMA];
					state_nxt.head = wb_dat_i[`FLC_DOR_HEAD];
				end
				`FLC_OFS_DSR: begin
					state_nxt.rate = wb_dat_i[1:0];
					state_nxt.pwrDown = wb_dat_i[`FLC_DSR_PDOWN];
					state_nxt.dsrRst = wb_dat_i[`FLC_DSR_RST];
				end
				`FLC_OFS_CRF0: begin
					state_nxt.mode = wb_dat_i[3:2];
					state_nxt.burst = wb_dat_i[1];
				end
				`FLC_OFS_SPEC: state_nxt.specDma = wb_dat_i[0];
				`FLC_OFS_CONF: begin
					state_nxt.fifoOff = wb_dat_i[0];
					state_nxt.pollOff = wb_dat_i[`FLC_CONF_POLL];
					state_nxt.thr = wb_dat_i[7:4];
					state_nxt.polling = state_r.polling
						& ~wb_dat_i[`FLC_CONF_POLL];
				end
				default: ;
			endcase
		end
		if (wr && wb_sel_i[1] && wb_adr_i == `FLC_OFS_SPEC) begin
			state_nxt.specTime = wb_dat_i[15:8];
		end

		// Core reset: output bit held, rate bit for one cycle
		if (state_nxt.dorRst || state_nxt.dsrRst) begin
			state_nxt.ph = PH_IDLE;
			state_nxt.cnt = 5'h00;
			state_nxt.wp = 4'h0;
			state_nxt.rp = 4'h0;
			state_nxt.request_for_master = 1'b0;
			state_nxt.transfer_direction_flag = 1'b0;
			state_nxt.cb = 1'b0;
			state_nxt.irq = 1'b0;
			state_nxt.req = 1'b0;
			state_nxt.pwrDown = 1'b0;
			state_nxt.fifoOff = 1'b1;
			state_nxt.thr = 4'h0;
			state_nxt.pollOff = 1'b0;
			state_nxt.polling = 1'b0;
		end else begin
			unique case (state_r.ph)
				// Leaving reset: wait for a command, polling on
				PH_IDLE: begin
					state_nxt.ph = PH_CMD;
					state_nxt.request_for_master = 1'b1;
					state_nxt.polling = 1'b1;
				end

				// Command bytes, one per request-for-master
				PH_CMD: begin
					if (wr && wb_adr_i == `FLC_OFS_DATA && state_r.request_for_master
						&& !state_r.transfer_direction_flag) begin
						state_nxt.request_for_master = 1'b0;
						state_nxt.cb = 1'b1;
						if (!state_r.cb) begin
							state_nxt.isData = wb_dat_i[`FLC_CMD_DATA];
							state_nxt.dirWr = wb_dat_i[`FLC_CMD_DIRWR];
							state_nxt.parLeft = wb_dat_i[3:0];
							state_nxt.st0 = {2'h0, 3'h0, state_r.head,
								state_r.ds};
							if (wb_dat_i[3:0] > `FLC_MAX_PARAMS) begin
								// Illegal: no further request, one byte
								state_nxt.ph = PH_RES;
								state_nxt.st0 = `FLC_ST_INVALID;
								state_nxt.resLen = 2'h1;
								state_nxt.resIdx = 2'h0;
								state_nxt.request_for_master = 1'b1;
								state_nxt.transfer_direction_flag = 1'b1;
								state_nxt.irq = 1'b1;
							end
						end else begin
							state_nxt.parLeft = state_r.parLeft - 4'h1;
							state_nxt.end_of_track_sector = wb_dat_i[7:0]; // last = end sector
						end
					end else if (state_r.cb && !state_r.request_for_master) begin
						if (state_r.parLeft != 4'h0) begin
							state_nxt.request_for_master = 1'b1;
						end else if (state_r.isData) begin
							state_nxt.ph = PH_EXEC;
							state_nxt.req = state_r.dirWr;
							state_nxt.secCnt = 8'h00;
							state_nxt.tcSeen = 1'b0;
							state_nxt.abn = 1'b0;
							state_nxt.ovr = 1'b0;
							state_nxt.fin = 1'b0;
							state_nxt.secInFifo = 1'b0;
						end else begin
							state_nxt.ph = PH_RES;
							state_nxt.resLen = `FLC_RES_LEN;
							state_nxt.resIdx = 2'h0;
							state_nxt.request_for_master = 1'b1;
							state_nxt.transfer_direction_flag = 1'b1;
							state_nxt.irq = 1'b1;
						end
					end
				end

				// Data transfer through the FIFO
				PH_EXEC: begin
					if (state_r.dirWr) begin
						push = dmaAck && state_r.cnt < cap;
						pushData = dmaWrData;
						if (diskWrTake) begin
							if (state_r.cnt != 5'h00) begin
								pop = 1'b1;
								state_nxt.diskWr = state_r.mem[state_r.rp];
							end else begin
								state_nxt.diskWr = 8'h00;
								state_nxt.abn = 1'b1;
								state_nxt.ovr = 1'b1;
							end
						end
					end else begin
						if (diskRdValid) begin
							push = state_r.cnt < cap;
							if (state_r.cnt >= cap) begin
								state_nxt.abn = 1'b1;
								state_nxt.ovr = 1'b1;
							end
						end
						if (dmaAck && state_r.cnt != 5'h00) begin
							pop = 1'b1;
							state_nxt.dmaRd = state_r.mem[state_r.rp];
						end
					end
					if (push) begin
						state_nxt.mem[state_r.wp] = pushData;
						state_nxt.wp = state_r.wp + 4'h1;
					end
					if (pop) begin
						state_nxt.rp = state_r.rp + 4'h1;
					end
					nc = state_r.cnt + {4'h0, push} - {4'h0, pop};
					state_nxt.cnt = nc;

					// Single transfer mode drops the request per byte
					state_nxt.gap = dmaAck & ~state_r.burst;

					if (terminalCountPulse) begin
						state_nxt.tcSeen = 1'b1;
					end
					if (diskSectorEnd) begin
						state_nxt.secCnt = state_r.secCnt + 8'h01;
						state_nxt.secInFifo = ~state_r.dirWr;
						if (state_r.tcSeen || terminalCountPulse
							|| state_nxt.abn
							|| state_r.secCnt + 8'h01 == state_r.end_of_track_sector) begin
							state_nxt.fin = 1'b1;
						end
					end

					// Request levels per direction
					if (state_r.dirWr) begin
						if (nc >= cap) begin
							state_nxt.req = 1'b0;
						end else if (cap - nc >= thrB) begin
							state_nxt.req = 1'b1;
						end
						if (state_nxt.tcSeen || state_nxt.fin) begin
							state_nxt.req = 1'b0;
						end
					end else begin
						if (nc >= lvl || (state_nxt.secInFifo
							&& nc != 5'h00)) begin
							state_nxt.req = 1'b1;
						end
						if (nc == 5'h00) begin
							state_nxt.req = 1'b0;
							state_nxt.secInFifo = 1'b0;
						end
					end

					// Finish once the read data is drained, or at once on abnormal end
					if (state_r.fin && (state_r.dirWr || nc == 5'h00
						|| state_r.abn)) begin
						state_nxt.ph = PH_RES;
						state_nxt.req = 1'b0;
						state_nxt.cnt = 5'h00;
						state_nxt.wp = 4'h0;
						state_nxt.rp = 4'h0;
						state_nxt.st0 = state_r.st0 | (state_r.abn
							? `FLC_ST_ABNORM : 8'h00);
						state_nxt.resLen = `FLC_RES_LEN;
						state_nxt.resIdx = 2'h0;
						state_nxt.request_for_master = 1'b1;
						state_nxt.transfer_direction_flag = 1'b1;
						state_nxt.irq = 1'b1;
					end
				end

				// Result bytes read out in order
				PH_RES: begin
					if (rd && wb_adr_i == `FLC_OFS_DATA && state_r.request_for_master
						&& state_r.transfer_direction_flag) begin
						state_nxt.irq = 1'b0;
						state_nxt.resIdx = state_r.resIdx + 2'h1;
						if (state_r.resIdx + 2'h1 == state_r.resLen) begin
							state_nxt.ph = PH_CMD;
							state_nxt.request_for_master = 1'b1;
							state_nxt.transfer_direction_flag = 1'b0;
							state_nxt.cb = 1'b0;
						end
					end
				end
				default: state_nxt.ph = PH_IDLE;
			endcase
		end

		// Pin reset clears all but the specify values
		if (!systemResetN) begin
			state_nxt = FLC_RST_STATE;
			state_nxt.specDma = state_r.specDma;
			state_nxt.specTime = state_r.specTime;
		end
	end

	// ****************************************
	// State register
	// ****************************************
	// Power-on reset clears everything, specify values included
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			state_r <= FLC_RST_STATE;
		end else begin
			state_r <= state_nxt;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign wb_ack_o = state_r.ack;
	assign wb_dat_o = state_r.dat;
	assign driveSelectLines = state_r.ds;
	assign headSideLine = state_r.head;
	assign pollingActive = state_r.polling;
	assign dmaRdData = state_r.dmaRd;
	assign diskWrData = state_r.diskWr;

	// Request only while specify enabled and the mode gate is open
	assign dmaReq = state_r.req & ~state_r.gap & state_r.specDma
		& gate & (state_r.ph == PH_EXEC);
	assign interruptOut = state_r.irq & gate;

	// Density polarity: high in the first mode and for mode value 3
	assign densitySelect = (state_r.mode == MODE_SECOND
		|| state_r.mode == MODE_THIRD)
		? state_r.rate != `FLC_RATE_HD
		: state_r.rate == `FLC_RATE_HD;

endmodule : flc_core

/* File: hw/flc_defines.svh */
// Register offsets, field positions, values and counts of the floppy control core
// Assumes a 32-bit classic Wishbone slave with byte addresses on adr[7:0]
`ifndef FLC_DEFINES_SVH
`define FLC_DEFINES_SVH

// ****************************************
// Register byte offsets
// ****************************************
`define FLC_OFS_DOR    8'h00
`define FLC_OFS_DSR    8'h04
`define FLC_OFS_MSR    8'h08
`define FLC_OFS_DATA   8'h0C
`define FLC_OFS_DRV    8'h10
`define FLC_OFS_CRF0   8'h14
`define FLC_OFS_SPEC   8'h18
`define FLC_OFS_CONF   8'h1C

// ****************************************
// Field positions
// ****************************************
`define FLC_DOR_RST    2
`define FLC_DOR_DMA    3
`define FLC_DOR_HEAD   4
`define FLC_DSR_PDOWN  6
`define FLC_DSR_RST    7
`define FLC_MSR_RQM    7
`define FLC_MSR_DIO    6
`define FLC_MSR_CB     4
`define FLC_MSR_EXEC   5
`define FLC_CMD_DIRWR  4
`define FLC_CMD_DATA   5
`define FLC_CONF_POLL  3

// ****************************************
// Values and counts
// ****************************************
`define FLC_MAX_PARAMS 4'h8
`define FLC_FIFO_DEPTH 5'h10
`define FLC_RES_LEN    2'h3
`define FLC_ST_INVALID 8'h80
`define FLC_ST_ABNORM  8'h40
`define FLC_ST_OVRUN   8'h10
`define FLC_RATE_HD    2'h0

`endif

/* File: hw/flc_pkg.sv */
// Types of the floppy control core: phases, interface modes, state record
// Assumes flc_defines.svh is on the include path
package flc_pkg;

	// ****************************************
	// Phases and modes
	// ****************************************
	typedef enum logic [3:0] {
		PH_IDLE = 4'h1,
		PH_CMD  = 4'h2,
		PH_EXEC = 4'h4,
		PH_RES  = 4'h8
	} flc_phase_t;

	typedef enum logic [1:0] {
		MODE_FIRST  = 2'h0,
		MODE_SECOND = 2'h1,
		MODE_THIRD  = 2'h2
	} flc_mode_t;

	// ****************************************
	// Whole state of the core
	// ****************************************
	typedef struct packed {
		flc_phase_t       ph;
		logic [1:0]       ds;
		logic             dorRst;
		logic             dorDma;
		logic             head;
		logic [1:0]       rate;
		logic             pwrDown;
		logic             dsrRst;
		logic [1:0]       mode;
		logic             burst;
		logic             specDma;
		logic [7:0]       specTime;
		logic             fifoOff;
		logic [3:0]       thr;
		logic             pollOff;
		logic             polling;
		logic [15:0][7:0] mem;
		logic [3:0]       wp;
		logic [3:0]       rp;
		logic [4:0]       cnt;
		logic             request_for_master;
		logic             transfer_direction_flag;
		logic             cb;
		logic             irq;
		logic [3:0]       parLeft;
		logic             isData;
		logic             dirWr;
		logic [7:0]       end_of_track_sector;
		logic [7:0]       secCnt;
		logic             tcSeen;
		logic             abn;
		logic             ovr;
		logic             fin;
		logic             secInFifo;
		logic [7:0]       st0;
		logic [1:0]       resIdx;
		logic [1:0]       resLen;
		logic             req;
		logic             gap;
		logic [7:0]       dmaRd;
		logic [7:0]       diskWr;
		logic             ack;
		logic [31:0]      dat;
	} flc_state_t;

	localparam flc_state_t FLC_RST_STATE = '{
		ph: PH_IDLE, dorRst: 1'b1, fifoOff: 1'b1, default: '0};

endpackage : flc_pkg

/* File: testbench/flc_core_sva.sv */
// Port checks of the floppy control core
// Assumes one clock domain and the async active-high reset rst
`timescale 1ns/1ps

module flc_core_sva
	import flc_pkg::*;
(
	input wire logic        ref_clk,
	input wire logic        rst,
	input wire logic [7:0]  wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic        wb_we_i,
	input wire logic [3:0]  wb_sel_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_cyc_i,
	input wire logic        wb_ack_o,
	input wire logic        systemResetN,
	input wire logic [1:0]  driveSelectLines,
	input wire logic        headSideLine,
	input wire logic        pollingActive,
	input wire logic        interruptOut,
	input wire logic        dmaReq
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	// ********
	// Bus request step, shared by the register checks
	// ********
	sequence req_s(logic [7:0] a, logic w);
		wb_cyc_i && wb_stb_i && !wb_ack_o && wb_adr_i == a && wb_we_i == w;
	endsequence

	ack_lat_a:
		assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("bus request not answered next cycle");
	ack_pulse_a:
		assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	dat_idle_a:
		assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
		else $error("read data outside ack");
	dor_lines_a:
		assert property (req_s(8'h00, 1'b1) ##0 wb_sel_i[0] |=>
			driveSelectLines == $past(wb_dat_i[1:0]) &&
			headSideLine == $past(wb_dat_i[4]))
		else $error("drive lines do not follow output register");
	drv_const_a:
		assert property (req_s(8'h10, 1'b0) ##1 wb_ack_o |->
			!wb_dat_o[7] && wb_dat_o[5] && wb_dat_o[3] &&
			wb_dat_o[2:0] == {headSideLine, driveSelectLines})
		else $error("drive state byte wrong");
	pin_abort_a:
		assert property (!systemResetN |=>
			!dmaReq && !interruptOut && !pollingActive)
		else $error("pin reset left activity running");
	por_quiet_a:
		assert property ($fell(rst) |-> !wb_ack_o && !dmaReq && !pollingActive)
		else $error("activity right after power-on reset");
	irq_clear_a:
		assert property (req_s(8'h0C, 1'b0) ##0 interruptOut ##1 wb_ack_o
			|-> !interruptOut)
		else $error("interrupt kept after first result read");
endmodule : flc_core_sva

bind flc_core flc_core_sva sva_i (.ref_clk, .rst, .wb_adr_i, .wb_dat_i,
	.wb_dat_o, .wb_we_i, .wb_sel_i, .wb_stb_i, .wb_cyc_i, .wb_ack_o,
	.systemResetN, .driveSelectLines, .headSideLine, .pollingActive,
	.interruptOut, .dmaReq);

/* File: testbench/flc_dma_model.sv */
// DMA controller model facing the floppy control core
// Assumes dmaReq is a level and dmaAck a one-cycle pulse per byte
`timescale 1ns/1ps

module flc_dma_model (
	input  wire logic       ref_clk,
	input  wire logic       rst,
	input  wire logic       slow,
	input  wire logic       dmaReq,
	output logic            dmaAck,
	output logic      [7:0] dmaWrData,
	input  wire logic [7:0] dmaRdData
);
	int         nAck;
	int         waitCnt;
	logic       pend;
	logic [7:0] rdQ[$];

	// ********
	// One byte per request; slow mode waits three cycles first
	// ********
	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			dmaAck <= 1'b0;
			pend <= 1'b0;
			nAck <= 0;
			waitCnt <= 0;
			dmaWrData <= 8'hFF;
		end else begin
			pend <= dmaAck;
			// Popped byte is valid the cycle after the ack
			if (pend)
				rdQ.push_back(dmaRdData);
			if (dmaAck) begin
				dmaAck <= 1'b0;
				dmaWrData <= ~dmaWrData; // Released data never keeps old byte
			end else if (dmaReq && (!slow || waitCnt == 3)) begin
				dmaAck <= 1'b1;
				dmaWrData <= 8'hA0 + nAck[7:0];
				nAck <= nAck + 1;
				waitCnt <= 0;
			end else if (dmaReq) begin
				waitCnt <= waitCnt + 1;
			end
		end
	end
endmodule : flc_dma_model

/* File: testbench/tb.sv */
// Self-checking bench of the floppy control core with a DMA model
// Assumes the hw files and the DMA model are compiled before this file
`timescale 1ns/1ps

module tb
	import flc_pkg::*;
;
	logic        ref_clk, rst, wb_we_i, wb_stb_i, wb_cyc_i, wb_ack_o;
	logic        systemResetN, writeProtIn, trackZeroIn, headSideLine;
	logic        densitySelect, pollingActive, interruptOut, dmaReq;
	logic        dmaAck, terminalCountPulse, diskRdValid, diskSectorEnd;
	logic        diskWrTake, slow;
	logic [1:0]  driveSelectLines;
	logic [3:0]  wb_sel_i;
	logic [7:0]  wb_adr_i, dmaWrData, dmaRdData, diskRdData, diskWrData;
	logic [31:0] wb_dat_i, wb_dat_o, rv;
	int          fails, nTests, n, b;

	flc_core dut (.ref_clk, .rst, .wb_adr_i, .wb_dat_i, .wb_dat_o,
		.wb_we_i, .wb_sel_i, .wb_stb_i, .wb_cyc_i, .wb_ack_o, .systemResetN,
		.writeProtIn, .trackZeroIn, .driveSelectLines, .headSideLine,
		.densitySelect, .pollingActive, .interruptOut, .dmaReq, .dmaAck,
		.dmaWrData, .dmaRdData, .terminalCountPulse, .diskRdValid,
		.diskRdData, .diskSectorEnd, .diskWrTake, .diskWrData);
	flc_dma_model dma (.ref_clk, .rst, .slow, .dmaReq, .dmaAck,
		.dmaWrData, .dmaRdData);

	// ********
	// Shared tasks
	// ********
	task chk(input logic [31:0] got, input logic [31:0] exp);
		nTests++;
		if (got !== exp) begin
			fails++;
			$display("[ERR] %0t got %h want %h", $time, got, exp);
		end
	endtask : chk

	// Classic cycle: everything held until ack is sampled high
	task wb(input logic [7:0] a, input logic w, input logic [31:0] d);
		@(posedge ref_clk);
		{wb_cyc_i, wb_stb_i, wb_we_i} <= {2'b11, w};
		wb_adr_i <= a;
		wb_dat_i <= d;
		n = 0;
		do begin
			@(posedge ref_clk);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 20);
		rv = wb_dat_o;
		if (n >= 20)
			chk(32'h0, 32'h1);
		{wb_cyc_i, wb_stb_i} <= 2'b00;
	endtask : wb

	task rdc(input logic [7:0] a, input logic [31:0] m, e);
		wb(a, 1'b0, 32'h0);
		chk(rv & m, e);
	endtask : rdc

	task cyc(input int c);
		repeat (c) @(posedge ref_clk);
	endtask : cyc

	// One-cycle pulse on the disk or terminal-count input picked by k
	task pulse(input int k);
		@(posedge ref_clk);
		{terminalCountPulse, diskWrTake, diskSectorEnd, diskRdValid} <= 4'h1 << k;
		@(posedge ref_clk);
		{terminalCountPulse, diskWrTake, diskSectorEnd, diskRdValid} <= 4'h0;
	endtask : pulse

	// Bounded wait for the result interrupt, then the three result bytes
	task res3(input logic [7:0] e0, e1, e2);
		for (n = 0; n < 300 && interruptOut !== 1'b1; n++)
			cyc(1);
		chk({31'h0, interruptOut}, 32'h1);
		rdc(8'h0C, 32'hFF, {24'h0, e0});
		rdc(8'h0C, 32'hFF, {24'h0, e1});
		rdc(8'h0C, 32'hFF, {24'h0, e2});
		rdc(8'h08, 32'hD0, 32'h80);
	endtask : res3

	// ********
	// Scenarios
	// ********
	task t_reset;
		rdc(8'h18, 32'hFFFF, 32'h0);
		rdc(8'h00, 32'hFF, 32'h04);
		rdc(8'h08, 32'hFF, 32'h0);
		rdc(8'h1C, 32'h1FF, 32'h001);
		wb(8'h00, 1'b1, 32'h08);
		rdc(8'h08, 32'hFF, 32'h80);
		chk({31'h0, pollingActive}, 32'h1);
	endtask : t_reset

	// Inputs settle a few cycles before the drive state is read
	task t_drive;
		for (int k = 0; k < 4; k++) begin
			{writeProtIn, trackZeroIn} <= {k[0], k[1]};
			wb(8'h00, 1'b1, {27'h1, k[0], 2'b10, k[1:0]});
			cyc(3);
			rdc(8'h10, 32'hFFFF_FFFF,
				{24'h0, 1'b0, k[0], 1'b1, k[1], 1'b1, k[0], k[1:0]});
		end
	endtask : t_drive

	task t_soft;
		wb(8'h1C, 1'b1, 32'h30);
		wb(8'h04, 1'b1, 32'h40);
		wb(8'h04, 1'b1, 32'h80);
		rdc(8'h04, 32'hC0, 32'h0);
		rdc(8'h1C, 32'hFF, 32'h01);
		wb(8'h00, 1'b1, 32'h0C);
		wb(8'h04, 1'b1, 32'h80);
		cyc(2);
		rdc(8'h08, 32'hFF, 32'h0);
		wb(8'h00, 1'b1, 32'h08);
		rdc(8'h08, 32'hFF, 32'h80);
	endtask : t_soft

	// Illegal command per mode with the output DMA gate off
	task t_modes;
		for (int m = 0; m < 3; m++) begin
			wb(8'h14, 1'b1, m << 2);
			wb(8'h00, 1'b1, 32'h0);
			chk({31'h0, densitySelect}, {31'h0, m == 0});
			wb(8'h0C, 1'b1, 32'h09);
			cyc(3);
			chk({31'h0, interruptOut}, {31'h0, m == 1});
			rdc(8'h08, 32'hC0, 32'hC0);
			rdc(8'h0C, 32'hFF, 32'h80);
			rdc(8'h08, 32'hD0, 32'h80);
		end
		wb(8'h14, 1'b1, 32'h0);
	endtask : t_modes

	// Disk read, one-byte FIFO, slow DMA answers
	task t_rd;
		wb(8'h00, 1'b1, 32'h19);
		wb(8'h18, 1'b1, 32'h01);
		slow <= 1'b1;
		b = dma.rdQ.size();
		rdc(8'h08, 32'hC0, 32'h80);
		wb(8'h0C, 1'b1, 32'h21);
		wb(8'h0C, 1'b1, 32'h01);
		for (int i = 0; i < 3; i++) begin
			diskRdData <= 8'h50 + i[7:0];
			pulse(0);
			for (n = 0; n < 100 && dma.rdQ.size() == b + i; n++)
				cyc(1);
			chk({24'h0, dma.rdQ[b + i]}, 32'h50 + i);
		end
		pulse(1);
		res3(8'h05, 8'h00, 8'h01);
	endtask : t_rd

	// Disk write, FIFO on, threshold four, burst mode
	task t_wr;
		slow <= 1'b0;
		wb(8'h1C, 1'b1, 32'h30);
		wb(8'h14, 1'b1, 32'h02);
		rdc(8'h14, 32'hFF, 32'h02);
		rdc(8'h08, 32'hC0, 32'h80);
		b = dma.nAck;
		wb(8'h0C, 1'b1, 32'h31);
		wb(8'h0C, 1'b1, 32'h01);
		for (n = 0; n < 200 && dma.nAck < b + 16; n++)
			cyc(1);
		cyc(8);
		chk(dma.nAck - b, 32'd16);
		for (int i = 0; i < 4; i++) begin
			pulse(2);
			@(negedge ref_clk);
			chk({24'h0, diskWrData}, (32'hA0 + b + i) & 32'hFF);
			if (i < 3)
				chk({31'h0, dmaReq}, 32'h0);
		end
		for (n = 0; n < 200 && dma.nAck < b + 20; n++)
			cyc(1);
		cyc(8);
		chk(dma.nAck - b, 32'd20);
		pulse(3);
		cyc(2);
		chk({31'h0, dmaReq}, 32'h0);
		pulse(1);
		res3(8'h05, 8'h00, 8'h01);
	endtask : t_wr

	// Pin reset in mid execution; specify values survive
	task t_pin;
		wb(8'h18, 1'b1, 32'h0301);
		wb(8'h0C, 1'b1, 32'h31);
		wb(8'h0C, 1'b1, 32'h01);
		cyc(4);
		systemResetN <= 1'b0;
		cyc(2);
		systemResetN <= 1'b1;
		chk({31'h0, dmaReq}, 32'h0);
		rdc(8'h18, 32'hFFFF, 32'h0301);
		rdc(8'h00, 32'hFF, 32'h04);
		rdc(8'h08, 32'hFF, 32'h0);
		wb(8'h00, 1'b1, 32'h19);
		rdc(8'h08, 32'hFF, 32'h80);
		rdc(8'h1C, 32'h1FF, 32'h101);
	endtask : t_pin

	task test_done;
		$display("fails %0d compares %0d", fails, nTests);
		if (fails == 0 && nTests > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : test_done

	// ********
	// Clock, watchdog and main sequence
	// ********
	initial begin
		ref_clk = 1'b0;
		forever #10 ref_clk = ~ref_clk;
	end

	// Whole run needs a few hundred cycles
	initial begin
		#200000;
		fails++;
		test_done;
	end

	initial begin
		{rst, systemResetN, wb_we_i, wb_stb_i, wb_cyc_i} = 5'h18;
		{terminalCountPulse, diskRdValid, diskSectorEnd} = 3'h0;
		{diskWrTake, slow, writeProtIn, trackZeroIn} = 4'h0;
		{wb_sel_i, wb_adr_i, diskRdData, wb_dat_i} = 52'h0;
		wb_sel_i = 4'hF;
		fails = 0;
		nTests = 0;
		cyc(5);
		rst <= 1'b0;
		t_reset;
		t_drive;
		t_soft;
		t_modes;
		t_rd;
		t_wr;
		t_pin;
		test_done;
	end
endmodule : tb
